/* File: common/crf_regs.svh */
// Constants of the CPU register file: offsets, fields, resets, steps.
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// -----------------------------------------------------------------
// Bus offsets, byte addresses of 32-bit words.
// -----------------------------------------------------------------
`define CRF_ADR_REGS  8'h00
`define CRF_ADR_FLAGS 8'h04
`define CRF_ADR_STAT  8'h08

// -----------------------------------------------------------------
// Field positions (least significant bit of each field).
// -----------------------------------------------------------------
`define CRF_F_A   0
`define CRF_F_B   4
`define CRF_F_X   8
`define CRF_F_Y   12
`define CRF_F_SPX 16
`define CRF_F_SPY 20
`define CRF_F_W   24
`define CRF_F_CA  0
`define CRF_F_ST  1
`define CRF_F_PC  0
`define CRF_F_SP  16

// -----------------------------------------------------------------
// Reset values and steps.
// -----------------------------------------------------------------
`define CRF_SP_RESET  10'h3ff
`define CRF_SP_STEP   10'h004
`define CRF_SP_FIXED  4'hf
`define CRF_LVL_RESET 4'hf
`define CRF_PC_RESET  14'h0000
`define CRF_ST_RESET  1'b1

`endif

/* File: common/crf_pkg.sv */
// Types shared by the CPU register file modules.
`default_nettype none
package crf_pkg;
	// Commands issued by the sequencer, one per instruction step.
	typedef enum logic [4:0] {
		CMD_NONE, CMD_LOAD, CMD_ARITH, CMD_COMPARE, CMD_TEST,
		CMD_SET_OVF, CMD_CLR_OVF, CMD_ROT_LEFT, CMD_ROT_RIGHT,
		CMD_NEAR_JUMP, CMD_LONG_JUMP, CMD_NEAR_CALL, CMD_LONG_CALL,
		CMD_SUB_RETURN, CMD_INT_ENTRY, CMD_INT_RETURN,
		CMD_CLR_BIT, CMD_CLR_BIT_DIRECT, CMD_STEP
	} crf_cmd_t;
	// Destination register of a load or an ALU result.
	typedef enum logic [2:0] {
		DST_A, DST_B, DST_W, DST_X, DST_Y, DST_SPX, DST_SPY
	} crf_dest_t;
	// One request from the sequencer and ALU.
	typedef struct packed {
		crf_cmd_t    cmd;
		crf_dest_t   dest;
		logic [3:0]  data;
		logic [13:0] target;
		logic        aluOvf;
		logic        testBit;
		logic        rsBit;
	} crf_op_t;
	// Visible contents of all working registers.
	typedef struct packed {
		logic [3:0]  a, b;
		logic [1:0]  w;
		logic [3:0]  x, y, aux_row_reg, aux_col_reg;
		logic        ca, st;
		logic [13:0] pc;
		logic [9:0]  sp;
	} crf_regs_t;
	// One stack slot: return address and both flags.
	typedef struct packed {
		logic [13:0] pc;
		logic        ca, st;
	} crf_slot_t;
	typedef crf_slot_t [15:0] crf_stack_t;
	// Whole state of the main module.
	typedef struct packed {
		logic [3:0]  a, b;
		logic [1:0]  w;
		logic [3:0]  x, y, aux_row_reg, aux_col_reg;
		logic        ca, st;
		logic [13:0] pc;
		crf_stack_t  stk;
		logic        ack;
		logic [31:0] rdat;
	} crf_state_t;
	// State of the save pointer: its stack level.
	typedef struct packed {
		logic [3:0] level;
	} crf_sp_state_t;
endpackage
`default_nettype wire

/* File: rtl/crf_save_pointer.sv */
// Save pointer: stack level counter with fixed upper bits.
`include "crf_regs.svh"
`default_nettype none
module crf_save_pointer (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       push,
	input  wire logic       pop,
	input  wire logic       reinit,
	output logic [3:0]      level,
	output logic [9:0]      savePtr
);
	// -------------------------------------------------------------
	// State.
	// -------------------------------------------------------------
	crf_pkg::crf_sp_state_t q, d; // Registered and next level.

	// Next level: reload wins over any step of the pointer.
	always_comb begin
		d = q;
		if (reinit) begin
			d.level = `CRF_LVL_RESET;
		end else if (push && !pop) begin
			d.level = q.level - 4'h1;
		end else if (pop && !push) begin
			d.level = q.level + 4'h1;
		end
	end

	// Register the level; reset puts the pointer at 3FF.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q.level <= `CRF_LVL_RESET;
		end else begin
			q <= d;
		end
	end

	// Each level is one step of four; upper bits never move.
	assign level   = q.level;
	assign savePtr = {`CRF_SP_FIXED, q.level, 2'b11};

	// -------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------
	AST_SP_UPPER: assert property (@(posedge sys_clk) disable iff (rst)
		savePtr[9:6] == `CRF_SP_FIXED) else $error("pointer top moved");
	AST_SP_REINIT: assert property (@(posedge sys_clk) disable iff (rst)
		reinit |=> savePtr == `CRF_SP_RESET) else $error("no reload");
	AST_SP_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
		push && !pop && !reinit |=> savePtr == $past(savePtr) - `CRF_SP_STEP)
		else $error("save step wrong");
endmodule
`default_nettype wire

/* File: rtl/crf_core.sv */
// CPU working registers, flags, ROM address counter and stack.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`include "crf_regs.svh"
`default_nettype none
module crf_core (
	input  wire logic           sys_clk,
	input  wire logic           rst,
	input  wire logic           wb_cyc_i,
	input  wire logic           wb_stb_i,
	input  wire logic           wb_we_i,
	input  wire logic [7:0]     wb_adr_i,
	input  wire logic [3:0]     wb_sel_i,
	input  wire logic [31:0]    wb_dat_i,
	output logic [31:0]         wb_dat_o,
	output logic                wb_ack_o,
	input  wire crf_pkg::crf_op_t op,
	output crf_pkg::crf_regs_t  regs,
	output logic [9:0]          ramAddr,
	output logic [3:0]          portBitSel,
	output logic                branchTaken
);
	// -------------------------------------------------------------
	// State and local signals.
	// -------------------------------------------------------------
	crf_pkg::crf_state_t q, d;   // Registered and next state.
	logic        busReq;         // New Wishbone request this cycle.
	logic        push;           // One slot is saved to the stack.
	logic        pop;            // One slot is restored from it.
	logic        reinit;         // The stack reinit bit is cleared.
	logic        condOp;         // A conditional transfer command.
	logic        taken;          // That transfer is carried out.
	logic [3:0]  level;          // Current stack level.
	logic [3:0]  popLevel;       // Level of the slot to restore.
	logic [9:0]  savePtr;        // Save pointer value.
	logic [13:0] pcNext;         // Address of the next instruction.
	logic [31:0] regWord;        // Packed working registers.
	crf_pkg::crf_slot_t popSlot; // Slot read on a restore.

	// -------------------------------------------------------------
	// Save pointer.
	// -------------------------------------------------------------
	crf_save_pointer u_sp (
		.sys_clk (sys_clk),
		.rst     (rst),
		.push    (push),
		.pop     (pop),
		.reinit  (reinit),
		.level   (level),
		.savePtr (savePtr)
	);

	// Decode of the stack and transfer commands.
	always_comb begin
		condOp = (op.cmd == crf_pkg::CMD_NEAR_JUMP) ||
			(op.cmd == crf_pkg::CMD_LONG_JUMP) ||
			(op.cmd == crf_pkg::CMD_NEAR_CALL) ||
			(op.cmd == crf_pkg::CMD_LONG_CALL);
		taken = condOp && q.st;
		push = (taken && ((op.cmd == crf_pkg::CMD_NEAR_CALL) ||
			(op.cmd == crf_pkg::CMD_LONG_CALL))) ||
			(op.cmd == crf_pkg::CMD_INT_ENTRY);
		pop = (op.cmd == crf_pkg::CMD_SUB_RETURN) ||
			(op.cmd == crf_pkg::CMD_INT_RETURN);
		// Only a clear of the reinit bit reloads the pointer.
		reinit = ((op.cmd == crf_pkg::CMD_CLR_BIT) ||
			(op.cmd == crf_pkg::CMD_CLR_BIT_DIRECT)) && op.rsBit;
		popLevel = level + 4'h1;
		popSlot = q.stk[popLevel];
		pcNext = q.pc + 14'h0001;
	end

	// Working registers packed as one bus word.
	always_comb begin
		regWord = 32'h0000_0000;
		regWord[`CRF_F_A +: 4]   = q.a;
		regWord[`CRF_F_B +: 4]   = q.b;
		regWord[`CRF_F_X +: 4]   = q.x;
		regWord[`CRF_F_Y +: 4]   = q.y;
		regWord[`CRF_F_SPX +: 4] = q.aux_row_reg;
		regWord[`CRF_F_SPY +: 4] = q.aux_col_reg;
		regWord[`CRF_F_W +: 2]   = q.w;
	end

	// -------------------------------------------------------------
	// Next state: bus access first, sequencer command on top.
	// -------------------------------------------------------------
	always_comb begin
		d = q;
		d.ack = 1'b0;
		busReq = wb_cyc_i && wb_stb_i && !q.ack;
		// The bus slave answers every request one cycle later.
		if (busReq) begin
			d.ack = 1'b1;
			case (wb_adr_i)
				`CRF_ADR_REGS: begin
					d.rdat = regWord;
					if (wb_we_i && wb_sel_i[0]) begin
						d.a = wb_dat_i[`CRF_F_A +: 4];
						d.b = wb_dat_i[`CRF_F_B +: 4];
					end
					if (wb_we_i && wb_sel_i[1]) begin
						d.x = wb_dat_i[`CRF_F_X +: 4];
						d.y = wb_dat_i[`CRF_F_Y +: 4];
					end
					if (wb_we_i && wb_sel_i[2]) begin
						d.aux_row_reg = wb_dat_i[`CRF_F_SPX +: 4];
						d.aux_col_reg = wb_dat_i[`CRF_F_SPY +: 4];
					end
					if (wb_we_i && wb_sel_i[3]) begin
						d.w = wb_dat_i[`CRF_F_W +: 2];
					end
				end
				`CRF_ADR_FLAGS: begin
					d.rdat = 32'h0000_0000;
					d.rdat[`CRF_F_CA] = q.ca;
					d.rdat[`CRF_F_ST] = q.st;
					if (wb_we_i && wb_sel_i[0]) begin
						d.ca = wb_dat_i[`CRF_F_CA];
						d.st = wb_dat_i[`CRF_F_ST];
					end
				end
				`CRF_ADR_STAT: begin
					// Read only: counter and pointer.
					d.rdat = 32'h0000_0000;
					d.rdat[`CRF_F_PC +: 14] = q.pc;
					d.rdat[`CRF_F_SP +: 10] = savePtr;
				end
				default: begin
					// Unmapped words read zero, writes are dropped.
					d.rdat = 32'h0000_0000;
				end
			endcase
		end
		// Sequencer command; it wins over a bus write to the same field.
		case (op.cmd)
			crf_pkg::CMD_NONE: begin
				// Nothing moves; both flags hold.
			end
			crf_pkg::CMD_LOAD, crf_pkg::CMD_ARITH: begin
				case (op.dest)
					crf_pkg::DST_A:   d.a = op.data;
					crf_pkg::DST_B:   d.b = op.data;
					crf_pkg::DST_W:   d.w = op.data[1:0];
					crf_pkg::DST_X:   d.x = op.data;
					crf_pkg::DST_Y:   d.y = op.data;
					crf_pkg::DST_SPX: d.aux_row_reg = op.data;
					crf_pkg::DST_SPY: d.aux_col_reg = op.data;
					default:          d.a = op.data;
				endcase
				if (op.cmd == crf_pkg::CMD_ARITH) begin
					d.ca = op.aluOvf;
					d.st = op.aluOvf;
				end
				d.pc = pcNext;
			end
			crf_pkg::CMD_COMPARE: begin
				d.st = op.aluOvf;
				d.pc = pcNext;
			end
			crf_pkg::CMD_TEST: begin
				d.st = op.testBit;
				d.pc = pcNext;
			end
			crf_pkg::CMD_SET_OVF: begin
				d.ca = 1'b1;
				d.pc = pcNext;
			end
			crf_pkg::CMD_CLR_OVF: begin
				d.ca = 1'b0;
				d.pc = pcNext;
			end
			crf_pkg::CMD_ROT_LEFT: begin
				// Accumulator rotates through the overflow bit.
				{d.ca, d.a} = {q.a, q.ca};
				d.pc = pcNext;
			end
			crf_pkg::CMD_ROT_RIGHT: begin
				{d.a, d.ca} = {q.ca, q.a};
				d.pc = pcNext;
			end
			crf_pkg::CMD_NEAR_JUMP, crf_pkg::CMD_LONG_JUMP,
			crf_pkg::CMD_NEAR_CALL, crf_pkg::CMD_LONG_CALL: begin
				if (taken) begin
					d.pc = op.target;
				end else begin
					d.pc = pcNext;
				end
				if (push) begin
					d.stk[level] = '{pc: pcNext, ca: q.ca, st: q.st};
				end
				d.st = 1'b1;
			end
			crf_pkg::CMD_SUB_RETURN: begin
				// Flags are left alone on a plain return.
				d.pc = popSlot.pc;
			end
			crf_pkg::CMD_INT_ENTRY: begin
				// The interrupted address and both flags are saved.
				d.stk[level] = '{pc: q.pc, ca: q.ca, st: q.st};
				d.pc = op.target;
			end
			crf_pkg::CMD_INT_RETURN: begin
				d.pc = popSlot.pc;
				d.ca = popSlot.ca;
				d.st = popSlot.st;
			end
			crf_pkg::CMD_CLR_BIT, crf_pkg::CMD_CLR_BIT_DIRECT,
			crf_pkg::CMD_STEP: begin
				// Other instructions advance with flags held; a clear of the reinit bit also reloads the pointer.
				d.pc = pcNext;
			end
			default: begin
				d.pc = pcNext;
			end
		endcase
	end

	// -------------------------------------------------------------
	// State register; reset gives the documented start values.
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q      <= '0;
			q.pc   <= `CRF_PC_RESET;
			q.st   <= `CRF_ST_RESET;
		end else begin
			q <= d;
		end
	end

	// -------------------------------------------------------------
	// Outputs.
	// -------------------------------------------------------------
	assign wb_dat_o    = q.rdat;
	assign wb_ack_o    = q.ack;
	assign branchTaken = taken;
	// Indirect RAM address: bank, row pointer, column pointer.
	assign ramAddr     = {q.w, q.x, q.y};
	// The column pointer also picks one line of the D port.
	assign portBitSel  = q.y;
	always_comb begin
		regs.a   = q.a;
		regs.b   = q.b;
		regs.w   = q.w;
		regs.x   = q.x;
		regs.y   = q.y;
		regs.aux_row_reg = q.aux_row_reg;
		regs.aux_col_reg = q.aux_col_reg;
		regs.ca  = q.ca;
		regs.st  = q.st;
		regs.pc  = q.pc;
		regs.sp  = savePtr;
	end

	// -------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_ST_RESET: assert property ($past(rst) |-> q.st && q.pc == 14'h0000)
		else $error("bad start after reset");
	AST_SP_RESET: assert property ($past(rst) |-> savePtr == 10'h3ff)
		else $error("pointer not 3FF after reset");
	AST_LOAD_A: assert property (
		op.cmd == crf_pkg::CMD_LOAD && op.dest == crf_pkg::DST_A
		|=> q.a == $past(op.data)) else $error("load lost");
	AST_CA_ARITH: assert property (op.cmd == crf_pkg::CMD_ARITH
		|=> q.ca == $past(op.aluOvf) && q.st == $past(op.aluOvf))
		else $error("overflow not taken");
	AST_ST_TEST: assert property (op.cmd == crf_pkg::CMD_TEST
		|=> q.st == $past(op.testBit)) else $error("test lost");
	AST_JUMP_TAKEN: assert property (condOp && q.st
		|=> q.pc == $past(op.target)) else $error("jump missed");
	AST_JUMP_SKIP: assert property (condOp && !q.st
		|=> q.pc == $past(q.pc) + 14'h0001)
		else $error("skip wrong");
	AST_ST_FORCED: assert property (condOp |=> q.st)
		else $error("flag not one after transfer");
	AST_ST_HOLD: assert property (op.cmd == crf_pkg::CMD_STEP && !busReq
		|=> $stable(q.st) && $stable(q.ca))
		else $error("flag moved");
	AST_RTN_KEEP: assert property (op.cmd == crf_pkg::CMD_SUB_RETURN
		&& !busReq |=> $stable(q.ca) && $stable(q.st))
		else $error("return touched flags");
	AST_INT_RESTORE: assert property (
		op.cmd == crf_pkg::CMD_INT_ENTRY ##1
		op.cmd == crf_pkg::CMD_INT_RETURN
		|=> q.ca == $past(q.ca, 2) && q.st == $past(q.st, 2)
		&& q.pc == $past(q.pc, 2)) else $error("restore wrong");
	AST_ACK_PULSE: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");

	COV_CALL_TAKEN: cover property (op.cmd == crf_pkg::CMD_LONG_CALL && q.st);
	COV_INT_ROUND: cover property (op.cmd == crf_pkg::CMD_INT_ENTRY ##[1:8]
		op.cmd == crf_pkg::CMD_INT_RETURN);
	COV_REINIT: cover property (reinit);
	COV_BUS_WRITE: cover property (busReq && wb_we_i);
endmodule
`default_nettype wire

/* File: verification/crf_seq_model.sv */
// Sequencer stand-in that feeds one command at a time to the core.
`default_nettype none
module crf_seq_model (
	input  wire logic           sys_clk,
	output var crf_pkg::crf_op_t op
);
	timeunit 1ns;
	timeprecision 1ps;

	// The sequencer is idle until the bench hands it a command.
	initial op = '0;

	// Presents a command for the next sampling edge.
	task automatic issue(input crf_pkg::crf_op_t o);
		op <= o;
	endtask

	// Withdraws the command; stale fields are inverted, not kept.
	task automatic release_op(input int gap);
		crf_pkg::crf_op_t t;
		t = ~op;
		t.cmd = crf_pkg::CMD_NONE;
		op <= t;
		// A slow sequencer idles for a while before the next step.
		repeat (gap) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

/* File: verification/cpu_register_file_flags_test.sv */
// Self-checking bench for the CPU register file and flags.
`default_nettype none
module cpu_register_file_flags_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Clock, bus and design signals.
	// ------------------------------------------------------------
	logic             sys_clk = 1'b0;
	logic             rst = 1'b1;
	logic             wbCyc = 1'b0;
	logic             wbStb = 1'b0;
	logic             wbWe = 1'b0;
	logic [7:0]       wbAdr = 8'h00;
	logic [3:0]       wbSel = 4'h0;
	logic [31:0]      wbDatW = 32'h0;
	logic [31:0]      wbDatR;
	logic             wbAck;
	crf_pkg::crf_op_t op;
	crf_pkg::crf_regs_t regs;
	logic [9:0]       ramAddr;
	logic [3:0]       portBitSel;
	logic             branchTaken;
	int               fails = 0;
	int               tests_run = 0;
	// Reference state kept by the bench.
	logic [13:0]      mPc;
	logic [3:0]       mLvl;
	logic             mCa;
	logic             mSt;
	logic [3:0]       mF [7];
	crf_pkg::crf_slot_t mStk [16];

	// The clock toggles every half period of 2 ns.
	always #2 sys_clk = ~sys_clk;

	crf_core u_dut (
		.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
		.wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.op(op), .regs(regs), .ramAddr(ramAddr), .portBitSel(portBitSel),
		.branchTaken(branchTaken)
	);
	crf_seq_model u_seq (.sys_clk(sys_clk), .op(op));

	// ------------------------------------------------------------
	// Reporting.
	// ------------------------------------------------------------
	// Compares one value and counts the outcome.
	task automatic check(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// One classic Wishbone cycle, released only after ack is seen.
	task automatic wb(input logic we, input logic [7:0] adr,
			input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'hf;
		wbDatW <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			conclude();
		end
		q = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Reference model.
	// ------------------------------------------------------------
	// Expected register word as the bus shows it.
	function automatic logic [31:0] regsWord();
		return {6'h00, mF[2][1:0], mF[6], mF[5], mF[4], mF[3], mF[1], mF[0]};
	endfunction

	// Saves a return address with both flags and steps the level down.
	task automatic push(input logic [13:0] pc);
		mStk[mLvl] = '{pc, mCa, mSt};
		mLvl--;
	endtask

	// Works out the effect of one command on the reference state.
	task automatic apply(input crf_pkg::crf_op_t o);
		logic [13:0] nx;
		nx = mPc + 14'h0001;
		case (o.cmd)
			crf_pkg::CMD_NONE: nx = mPc;
			crf_pkg::CMD_LOAD: mF[o.dest] = o.data;
			crf_pkg::CMD_ARITH: begin
				mF[o.dest] = o.data;
				mCa = o.aluOvf;
				mSt = o.aluOvf;
			end
			crf_pkg::CMD_COMPARE: mSt = o.aluOvf;
			crf_pkg::CMD_TEST: mSt = o.testBit;
			crf_pkg::CMD_SET_OVF: mCa = 1'b1;
			crf_pkg::CMD_CLR_OVF: mCa = 1'b0;
			crf_pkg::CMD_ROT_LEFT: {mCa, mF[0]} = {mF[0], mCa};
			crf_pkg::CMD_ROT_RIGHT: {mF[0], mCa} = {mCa, mF[0]};
			crf_pkg::CMD_NEAR_JUMP, crf_pkg::CMD_LONG_JUMP: begin
				if (mSt) nx = o.target;
				mSt = 1'b1;
			end
			crf_pkg::CMD_NEAR_CALL, crf_pkg::CMD_LONG_CALL: begin
				if (mSt) begin
					push(nx);
					nx = o.target;
				end
				mSt = 1'b1;
			end
			crf_pkg::CMD_INT_ENTRY: begin
				push(mPc);
				nx = o.target;
			end
			crf_pkg::CMD_SUB_RETURN, crf_pkg::CMD_INT_RETURN: begin
				mLvl++;
				nx = mStk[mLvl].pc;
				if (o.cmd == crf_pkg::CMD_INT_RETURN) begin
					mCa = mStk[mLvl].ca;
					mSt = mStk[mLvl].st;
				end
			end
			crf_pkg::CMD_CLR_BIT, crf_pkg::CMD_CLR_BIT_DIRECT: begin
				if (o.rsBit) mLvl = 4'hf;
			end
			default: ;
		endcase
		mPc = nx;
	endtask

	// Runs one command and compares every visible register.
	task automatic step(input crf_pkg::crf_op_t o);
		logic cond;
		cond = o.cmd inside {[crf_pkg::CMD_NEAR_JUMP:crf_pkg::CMD_LONG_CALL]};
		u_seq.issue(o);
		#1;
		check("branchTaken", 32'(branchTaken), 32'(cond & mSt));
		apply(o);
		@(posedge sys_clk);
		// An interrupt entry is followed at once by the next command.
		u_seq.release_op((o.cmd == crf_pkg::CMD_INT_ENTRY) ? 0 :
			int'($urandom_range(1)));
		#1;
		check("pc", 32'(regs.pc), 32'(mPc));
		check("sp", 32'(regs.sp), {22'h0, 4'hf, mLvl, 2'h3});
		check("ca", 32'(regs.ca), 32'(mCa));
		check("st", 32'(regs.st), 32'(mSt));
		check("regs", {6'h00, regs.w, regs.aux_col_reg, regs.aux_row_reg, regs.y, regs.x,
			regs.b, regs.a}, regsWord());
		check("ramAddr", 32'(ramAddr), 32'({mF[2][1:0], mF[3], mF[4]}));
		check("portBitSel", 32'(portBitSel), 32'(mF[4]));
	endtask

	// Random command fields; the caller picks the command.
	function automatic crf_pkg::crf_op_t rnd();
		crf_pkg::crf_op_t o;
		o.cmd = crf_pkg::CMD_STEP;
		o.dest = crf_pkg::crf_dest_t'($urandom_range(6));
		{o.data, o.target, o.aluOvf, o.testBit, o.rsBit} = 21'($urandom);
		return o;
	endfunction

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		crf_pkg::crf_op_t o;
		logic [31:0] q;
		int unsigned c;
		int unsigned sq [13] = '{5, 4, 14, 15, 2, 4, 4, 12, 5, 4, 13, 16, 17};
		bit bt [13] = '{0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 1};
		void'($urandom(5));
		mPc = 14'h0000;
		mLvl = 4'hf;
		mCa = 1'b0;
		mSt = 1'b1;
		mF = '{default: 4'h0};
		mStk = '{default: '0};
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		// Reset state as read over the bus.
		wb(1'b0, 8'h08, 32'h0, q);
		check("stat", q, 32'h03ff_0000);
		wb(1'b0, 8'h04, 32'h0, q);
		check("flags", q, 32'h0000_0002);
		// Every conditional transfer with the flag low and high.
		for (int k = 0; k < 8; k++) begin
			o = rnd();
			o.cmd = crf_pkg::CMD_TEST;
			o.testBit = k[0];
			step(o);
			o.cmd = crf_pkg::crf_cmd_t'(9 + k / 2);
			step(o);
		end
		// Interrupt and subroutine returns, then a clear bit without reinit and a direct clear with it.
		for (int k = 0; k < 13; k++) begin
			o = rnd();
			o.cmd = crf_pkg::crf_cmd_t'(sq[k]);
			{o.aluOvf, o.testBit, o.rsBit} = {3{bt[k]}};
			step(o);
		end
		// Random commands, kept inside the sixteen stack levels.
		for (int k = 0; k < 300; k++) begin
			o = rnd();
			c = $urandom_range(18);
			if ((c == 13 || c == 15) && mLvl == 4'hf) c = 18;
			if ((c == 14 || c > 10 && c < 13 && mSt) && mLvl == 4'h0) c = 18;
			o.cmd = crf_pkg::crf_cmd_t'(c);
			step(o);
		end
		// Bus view of registers and flags, a read-only and a hole.
		wb(1'b0, 8'h00, 32'h0, q);
		check("regsBus", q, regsWord());
		c = $urandom;
		wb(1'b1, 8'h00, c, q);
		{mF[2], mF[6], mF[5], mF[4], mF[3], mF[1], mF[0]} = {2'h0, c[25:0]};
		wb(1'b1, 8'h04, 32'h1, q);
		wb(1'b1, 8'h08, 32'hffff_ffff, q);
		wb(1'b1, 8'h10, 32'hffff_ffff, q);
		mCa = 1'b1;
		mSt = 1'b0;
		o = rnd();
		o.cmd = crf_pkg::CMD_NEAR_JUMP;
		step(o);
		wb(1'b0, 8'h10, 32'h0, q);
		check("hole", q, 32'h0);
		wb(1'b0, 8'h08, 32'h0, q);
		check("stat2", q, {6'h00, 4'hf, mLvl, 2'h3, 2'h0, mPc});
		conclude();
	end

	// Cuts a hung run short.
	initial begin
		#200000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire
